// ==== logic/lcr_evt.sv ====
// Per-channel event detection, sticky interrupt status and error counter
`timescale 1ns/1ns
`include "lcr_regs.svh"
module lcr_evt (
   // Clock and control
   input wire logic clock,
   input wire logic reset,
   input wire logic ce,
   // Link to the register bank
   lcr_evt_if.evt port
);
   lcr_pkg::lcr_alarm_t alarm_q;
   lcr_pkg::lcr_irq_t status_q;
   lcr_pkg::lcr_irq_t status_d;
   lcr_pkg::lcr_count_t count_q;
   lcr_pkg::lcr_count_t count_d;
   lcr_pkg::lcr_byte_t hold_q;
   logic irq_q;
   wire lcr_pkg::lcr_alarm_t change;
   wire lcr_pkg::lcr_irq_t event_v;
   wire lcr_pkg::lcr_irq_t en_eff;
   wire lcr_pkg::lcr_irq_t set_v;
   wire count_full;
   wire sat_event;

   // Alarm edges in both directions count as events
   assign change = port.alarm ^ alarm_q;
   assign count_full = (count_q == `LCR_COUNT_MAX);
   assign sat_event = port.pattern_error && (count_q == (`LCR_COUNT_MAX - 16'h0001)); // RULE15

   // Event sources in interrupt-bit order
   assign event_v[`LCR_IRQ_DMO] = change[`LCR_AL_DMO]; // RULE9
   assign event_v[`LCR_IRQ_RLOS] = change[`LCR_AL_RLOS]; // RULE10
   assign event_v[`LCR_IRQ_RLOL] = change[`LCR_AL_RLOL]; // RULE11
   assign event_v[`LCR_IRQ_FL] = change[`LCR_AL_FL]; // RULE17
   assign event_v[`LCR_IRQ_PERR] = port.pattern_error; // RULE14
   assign event_v[`LCR_IRQ_PSAT] = sat_event; // RULE15

   // The FIFO-limit enable means nothing while the attenuator is off
   assign en_eff = {port.irq_en[5:4], port.irq_en[3] & port.ja_on, port.irq_en[2:0]}; // RULE13
   assign set_v = event_v & en_eff; // RULE9 RULE10 RULE11 RULE12

   // A new event in the read cycle survives the clear
   assign status_d = (port.rd_status ? 6'h00 : status_q) | set_v; // RULE16

   // Counter saturates rather than wrapping, so a full count stays visible
   assign count_d = (port.pattern_error && !count_full) ? count_q + 16'h0001 : count_q; // RULE7

   // State update
   always_ff @(posedge clock) begin
      if (reset) begin
         alarm_q <= 7'h00;
         status_q <= 6'h00;
         count_q <= `LCR_RST_COUNT;
         hold_q <= 8'h00;
         irq_q <= 1'b0;
      end else if (ce) begin
         alarm_q <= port.alarm;
         status_q <= status_d;
         count_q <= count_d;
         irq_q <= |(status_d & en_eff); // RULE18
         if (port.rd_msb) begin
            hold_q <= count_q[7:0]; // RULE8
         end
      end
   end

   assign port.status = status_q;
   assign port.count = count_q;
   assign port.hold = hold_q;
   assign port.alarm_seen = alarm_q;
   assign port.irq = irq_q;
endmodule

// ==== logic/lcr_evt_if.sv ====
// Signals between the register bank and one channel's event logic
`timescale 1ns/1ns
interface lcr_evt_if;
   lcr_pkg::lcr_irq_t irq_en;
   logic ja_on;
   logic rd_status;
   logic rd_msb;
   lcr_pkg::lcr_alarm_t alarm;
   logic pattern_error;
   lcr_pkg::lcr_irq_t status;
   lcr_pkg::lcr_count_t count;
   lcr_pkg::lcr_byte_t hold;
   lcr_pkg::lcr_alarm_t alarm_seen;
   logic irq;

   modport bank (
      output irq_en, ja_on, rd_status, rd_msb, alarm, pattern_error,
      input status, count, hold, alarm_seen, irq
   );
   modport evt (
      input irq_en, ja_on, rd_status, rd_msb, alarm, pattern_error,
      output status, count, hold, alarm_seen, irq
   );
endinterface

// ==== logic/lcr_pkg.sv ====
// Types shared by the channel register bank
package lcr_pkg;
   typedef logic [7:0] lcr_byte_t;
   typedef logic [3:0] lcr_off_t;
   typedef logic [15:0] lcr_count_t;
   typedef logic [5:0] lcr_irq_t;
   typedef logic [6:0] lcr_alarm_t;

   // Host port access phase, Gray coded along idle, take, finish
   typedef enum logic [1:0] {
      LCR_IDLE = 2'b00,
      LCR_TAKE = 2'b01,
      LCR_DONE = 2'b11
   } lcr_phase_t;
endpackage

// ==== logic/lcr_regs.svh ====
// Offsets, field positions, reset values and write masks of the register bank
`ifndef LCR_REGS_SVH
`define LCR_REGS_SVH

// Channel layout
`define LCR_CHAN_COUNT 6
`define LCR_CHAN_STRIDE 16

// Offsets inside one channel window
`define LCR_OFF_IRQ_EN 4'h1
`define LCR_OFF_IRQ_STAT 4'h2
`define LCR_OFF_ALARM 4'h3
`define LCR_OFF_TX_CTRL 4'h4
`define LCR_OFF_RX_CTRL 4'h5
`define LCR_OFF_BLK_CTRL 4'h6
`define LCR_OFF_JA_CTRL 4'h7
`define LCR_OFF_CNT_HI 4'ha
`define LCR_OFF_CNT_LO 4'hb
`define LCR_OFF_CNT_HOLD 4'hc

// Interrupt enable and status bit positions
`define LCR_IRQ_DMO 0
`define LCR_IRQ_RLOS 1
`define LCR_IRQ_RLOL 2
`define LCR_IRQ_FL 3
`define LCR_IRQ_PERR 4
`define LCR_IRQ_PSAT 5

// Alarm status bit positions
`define LCR_AL_DMO 0
`define LCR_AL_RLOS 1
`define LCR_AL_RLOL 2
`define LCR_AL_FL 3
`define LCR_AL_ALOS 4
`define LCR_AL_DLOS 5
`define LCR_AL_LOCK 6

// Transmit control bit positions
`define LCR_TX_LEV 0
`define LCR_TX_CLKINV 1
`define LCR_TX_ALLONES 2
`define LCR_TX_INSERT 4
`define LCR_TX_MON 5

// Receive control bit positions
`define LCR_RX_EQ 0
`define LCR_RX_MON 1
`define LCR_RX_MUTE 2
`define LCR_RX_CLKINV 3
`define LCR_RX_ALOSDIS 4
`define LCR_RX_DLOSDIS 5

// Block control bit positions
`define LCR_BK_RAIL 0
`define LCR_BK_SONET 1
`define LCR_BK_E3 2
`define LCR_BK_LLB 3
`define LCR_BK_RLB 4
`define LCR_BK_PGEN 5
`define LCR_BK_CLKOUT 6

// Jitter attenuator control bit positions
`define LCR_JA_MODE_LO 0
`define LCR_JA_PATH 1
`define LCR_JA_MODE_HI 2
`define LCR_JA_PTRRST 3
`define LCR_JA_LOCKDIS 4

// Writable bits; reserved bits read as zero
`define LCR_MASK_IRQ_EN 8'h3f
`define LCR_MASK_TX 8'h37
`define LCR_MASK_RX 8'h3f
`define LCR_MASK_BLK 8'h7f
`define LCR_MASK_JA 8'h1f

// Reset values
`define LCR_RST_IRQ_EN 8'h00
`define LCR_RST_TX 8'h00
`define LCR_RST_RX 8'h00
`define LCR_RST_BLK 8'h00
`define LCR_RST_JA 8'h00
`define LCR_RST_COUNT 16'h0000

// Error counter ceiling
`define LCR_COUNT_MAX 16'hffff

`endif

// ==== logic/lcr_top.sv ====
// Six-channel control, alarm and interrupt-enable register bank behind the host port
// Summary of operation
// RULE1: Each channel register repeats for six channels, sixteen addresses apart.
// RULE2: Alarm status reads lock, digital loss, analog loss, FIFO limit, lock loss, loss, monitor.
// RULE3: Transmit control holds monitor, pattern insert, all ones, clock invert, level.
// RULE4: Receive control holds two loss disables, clock invert, mute, monitor, equalizer.
// RULE5: Block control holds clock out, pattern enable, loopbacks, rate selects, rail mode.
// RULE6: Attenuator control holds lock disable, pointer reset, mode bits, path select.
// RULE7: Sixteen-bit pattern error count is read as high and low bytes.
// RULE8: A holding register after the low byte is readable per channel.
// RULE9: Driver monitor change sets its flag only when enable bit 0 is set.
// RULE10: Receive signal loss interrupts only while enable bit 1 is set.
// RULE11: Receive lock loss interrupts only while enable bit 2 is set.
// RULE12: FIFO near-limit interrupts while enable bit 3 is set.
// RULE13: FIFO-limit enable is ignored while the attenuator is disabled.
// RULE14: Pattern bit error interrupts only while enable bit 4 is set.
// RULE15: Error counter saturation interrupts only while enable bit 5 is set.
// RULE16: Reading the interrupt status register clears its flags.
// RULE17: FIFO-limit flag is set on entering and on leaving the limit.
// RULE18: Channel request is OR of enabled flags, gated by the channel gate.
`timescale 1ns/1ns
`include "lcr_regs.svh"
module lcr_top #(
   parameter int CHANNELS = `LCR_CHAN_COUNT
) (
   // Clock, reset and freeze
   input wire logic clock,
   input wire logic reset,
   input wire logic ce,
   // Host port, synchronous, strobes active low
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic rdy_n,
   // Alarm and event inputs from the line engines
   input wire logic [CHANNELS-1:0] pattern_lock_state,
   input wire logic [CHANNELS-1:0] digital_signal_loss,
   input wire logic [CHANNELS-1:0] analog_signal_loss,
   input wire logic [CHANNELS-1:0] fifo_limit_alarm,
   input wire logic [CHANNELS-1:0] receive_lock_loss,
   input wire logic [CHANNELS-1:0] receive_signal_loss,
   input wire logic [CHANNELS-1:0] driver_monitor_alarm,
   input wire logic [CHANNELS-1:0] pattern_error,
   // Global per-channel interrupt gate
   input wire logic [CHANNELS-1:0] channel_irq_gate,
   // Interrupt requests
   output logic [CHANNELS-1:0] channel_irq,
   // Transmit controls
   output logic [CHANNELS-1:0] transmit_monitor_enable,
   output logic [CHANNELS-1:0] pattern_insert,
   output logic [CHANNELS-1:0] transmit_all_ones,
   output logic [CHANNELS-1:0] transmit_clock_invert,
   output logic [CHANNELS-1:0] transmit_level_select,
   // Receive controls
   output logic [CHANNELS-1:0] digital_loss_disable,
   output logic [CHANNELS-1:0] analog_loss_disable,
   output logic [CHANNELS-1:0] receive_clock_invert,
   output logic [CHANNELS-1:0] mute_on_signal_loss,
   output logic [CHANNELS-1:0] receive_monitor_mode,
   output logic [CHANNELS-1:0] equalizer_enable,
   // Block controls
   output logic [CHANNELS-1:0] clock_output_enable,
   output logic [CHANNELS-1:0] pattern_generator_enable,
   output logic [CHANNELS-1:0] remote_loopback,
   output logic [CHANNELS-1:0] local_loopback,
   output logic [CHANNELS-1:0] e3_rate_select,
   output logic [CHANNELS-1:0] sonet_vs_ds3_select,
   output logic [CHANNELS-1:0] single_dual_rail,
   // Jitter attenuator controls
   output logic [CHANNELS-1:0] lock_disable_control,
   output logic [CHANNELS-1:0] fifo_pointer_reset,
   output logic [CHANNELS-1:0] attenuator_mode_hi,
   output logic [CHANNELS-1:0] attenuator_path_select,
   output logic [CHANNELS-1:0] attenuator_mode_lo
);
   lcr_pkg::lcr_phase_t phase_q;
   lcr_pkg::lcr_phase_t phase_d;
   lcr_pkg::lcr_byte_t rdata_q;
   logic oe_q;
   logic rdy_n_q;
   logic [CHANNELS-1:0] irq_q;
   lcr_pkg::lcr_byte_t ie_q [CHANNELS];
   lcr_pkg::lcr_byte_t tx_q [CHANNELS];
   lcr_pkg::lcr_byte_t rx_q [CHANNELS];
   lcr_pkg::lcr_byte_t blk_q [CHANNELS];
   lcr_pkg::lcr_byte_t ja_q [CHANNELS];
   lcr_pkg::lcr_byte_t chan_rdata [CHANNELS];
   logic [CHANNELS-1:0] chan_irq_raw;
   lcr_pkg::lcr_byte_t rdata_mux;

   // Strobe decode: a request is taken once per strobe assertion
   wire rd_act = !cs_n && !rd_n;
   wire wr_act = !cs_n && !wr_n;
   wire take = (phase_q == lcr_pkg::LCR_IDLE) && (rd_act || wr_act);
   wire take_rd = take && rd_act;
   wire take_wr = take && !rd_act && wr_act;
   wire [3:0] sel_chan = addr[7:4]; // RULE1
   wire lcr_pkg::lcr_off_t sel_off = addr[3:0];
   wire chan_ok = ({28'h0000_000, sel_chan} < CHANNELS);

   // Host port phase sequence
   always_comb begin
      phase_d = phase_q;
      case (phase_q)
         lcr_pkg::LCR_IDLE: begin
            if (rd_act || wr_act) begin
               phase_d = lcr_pkg::LCR_TAKE;
            end
         end
         lcr_pkg::LCR_TAKE: begin
            phase_d = lcr_pkg::LCR_DONE;
         end
         lcr_pkg::LCR_DONE: begin
            if (!rd_act && !wr_act) begin
               phase_d = lcr_pkg::LCR_IDLE;
            end
         end
         default: begin
            phase_d = lcr_pkg::LCR_IDLE;
         end
      endcase
   end

   // Read data selection; unmapped addresses read zero
   assign rdata_mux = chan_ok ? chan_rdata[sel_chan[$clog2(CHANNELS)-1:0]] : 8'h00;

   // Host port outputs; ready follows the take by two cycles and holds with the strobe
   always_ff @(posedge clock) begin
      if (reset) begin
         phase_q <= lcr_pkg::LCR_IDLE;
         rdata_q <= 8'h00;
         oe_q <= 1'b0;
         rdy_n_q <= 1'b1;
      end else if (ce) begin
         phase_q <= phase_d;
         if (take_rd) begin
            rdata_q <= rdata_mux;
         end
         oe_q <= rd_act && (phase_d != lcr_pkg::LCR_IDLE);
         rdy_n_q <= !(phase_d == lcr_pkg::LCR_DONE);
      end
   end

   // Per-channel registers and event logic
   for (genvar n = 0; n < CHANNELS; n++) begin : g_chan
      lcr_evt_if link ();
      wire hit = chan_ok && (sel_chan == 4'(n)); // RULE1
      wire wr_hit = take_wr && hit;

      // Register writes keep only defined bits
      always_ff @(posedge clock) begin
         if (reset) begin
            ie_q[n] <= `LCR_RST_IRQ_EN;
            tx_q[n] <= `LCR_RST_TX;
            rx_q[n] <= `LCR_RST_RX;
            blk_q[n] <= `LCR_RST_BLK;
            ja_q[n] <= `LCR_RST_JA;
         end else if (ce && wr_hit) begin
            if (sel_off == `LCR_OFF_IRQ_EN) begin
               ie_q[n] <= data_in & `LCR_MASK_IRQ_EN; // RULE9 RULE14
            end
            if (sel_off == `LCR_OFF_TX_CTRL) begin
               tx_q[n] <= data_in & `LCR_MASK_TX; // RULE3
            end
            if (sel_off == `LCR_OFF_RX_CTRL) begin
               rx_q[n] <= data_in & `LCR_MASK_RX; // RULE4
            end
            if (sel_off == `LCR_OFF_BLK_CTRL) begin
               blk_q[n] <= data_in & `LCR_MASK_BLK; // RULE5
            end
            if (sel_off == `LCR_OFF_JA_CTRL) begin
               ja_q[n] <= data_in & `LCR_MASK_JA; // RULE6
            end
         end
      end

      // Side effects of reads: status clear and count capture
      assign link.irq_en = ie_q[n][5:0];
      assign link.ja_on = ja_q[n][`LCR_JA_MODE_HI] | ja_q[n][`LCR_JA_MODE_LO]; // RULE13
      assign link.rd_status = take_rd && hit && (sel_off == `LCR_OFF_IRQ_STAT); // RULE16
      assign link.rd_msb = take_rd && hit && (sel_off == `LCR_OFF_CNT_HI); // RULE8
      assign link.pattern_error = pattern_error[n];

      // Alarm inputs in status-register order
      assign link.alarm = {pattern_lock_state[n], digital_signal_loss[n], analog_signal_loss[n],
         fifo_limit_alarm[n], receive_lock_loss[n], receive_signal_loss[n],
         driver_monitor_alarm[n]};

      lcr_evt u_evt (
         .clock(clock),
         .reset(reset),
         .ce(ce),
         .port(link)
      );

      // Channel read decode
      always_comb begin
         case (sel_off)
            `LCR_OFF_IRQ_EN: chan_rdata[n] = ie_q[n];
            `LCR_OFF_IRQ_STAT: chan_rdata[n] = {2'b00, link.status};
            `LCR_OFF_ALARM: chan_rdata[n] = {1'b0, link.alarm_seen}; // RULE2
            `LCR_OFF_TX_CTRL: chan_rdata[n] = tx_q[n];
            `LCR_OFF_RX_CTRL: chan_rdata[n] = rx_q[n];
            `LCR_OFF_BLK_CTRL: chan_rdata[n] = blk_q[n];
            `LCR_OFF_JA_CTRL: chan_rdata[n] = ja_q[n];
            `LCR_OFF_CNT_HI: chan_rdata[n] = link.count[15:8]; // RULE7
            `LCR_OFF_CNT_LO: chan_rdata[n] = link.count[7:0]; // RULE7
            `LCR_OFF_CNT_HOLD: chan_rdata[n] = link.hold; // RULE8
            default: chan_rdata[n] = 8'h00;
         endcase
      end

      assign chan_irq_raw[n] = link.irq;

      // Control fields straight from their registers
      assign transmit_monitor_enable[n] = tx_q[n][`LCR_TX_MON];
      assign pattern_insert[n] = tx_q[n][`LCR_TX_INSERT];
      assign transmit_all_ones[n] = tx_q[n][`LCR_TX_ALLONES];
      assign transmit_clock_invert[n] = tx_q[n][`LCR_TX_CLKINV];
      assign transmit_level_select[n] = tx_q[n][`LCR_TX_LEV];
      assign digital_loss_disable[n] = rx_q[n][`LCR_RX_DLOSDIS];
      assign analog_loss_disable[n] = rx_q[n][`LCR_RX_ALOSDIS];
      assign receive_clock_invert[n] = rx_q[n][`LCR_RX_CLKINV];
      assign mute_on_signal_loss[n] = rx_q[n][`LCR_RX_MUTE];
      assign receive_monitor_mode[n] = rx_q[n][`LCR_RX_MON];
      assign equalizer_enable[n] = rx_q[n][`LCR_RX_EQ];
      assign clock_output_enable[n] = blk_q[n][`LCR_BK_CLKOUT];
      assign pattern_generator_enable[n] = blk_q[n][`LCR_BK_PGEN];
      assign remote_loopback[n] = blk_q[n][`LCR_BK_RLB];
      assign local_loopback[n] = blk_q[n][`LCR_BK_LLB];
      assign e3_rate_select[n] = blk_q[n][`LCR_BK_E3];
      assign sonet_vs_ds3_select[n] = blk_q[n][`LCR_BK_SONET];
      assign single_dual_rail[n] = blk_q[n][`LCR_BK_RAIL];
      assign lock_disable_control[n] = ja_q[n][`LCR_JA_LOCKDIS];
      assign fifo_pointer_reset[n] = ja_q[n][`LCR_JA_PTRRST];
      assign attenuator_mode_hi[n] = ja_q[n][`LCR_JA_MODE_HI];
      assign attenuator_path_select[n] = ja_q[n][`LCR_JA_PATH];
      assign attenuator_mode_lo[n] = ja_q[n][`LCR_JA_MODE_LO];
   end

   // Channel requests are re-registered so the gate acts without a combinational path
   always_ff @(posedge clock) begin
      if (reset) begin
         irq_q <= '0;
      end else if (ce) begin
         irq_q <= chan_irq_raw & channel_irq_gate; // RULE18
      end
   end

   assign data_out = rdata_q;
   assign data_oe = oe_q;
   assign rdy_n = rdy_n_q;
   assign channel_irq = irq_q;
endmodule

// ==== verification/lcr_top_props.sv ====
// Host port, interrupt gate and control register assertions
`timescale 1ns/1ns
module lcr_top_props #(
   parameter int CHANNELS = 6
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   input wire logic ce,
   // Host port
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic rdy_n,
   // Interrupt gate and request
   input wire logic [CHANNELS-1:0] channel_irq_gate,
   input wire logic [CHANNELS-1:0] channel_irq,
   // Control outputs watched
   input wire logic [CHANNELS-1:0] transmit_level_select,
   input wire logic [CHANNELS-1:0] equalizer_enable,
   input wire logic [CHANNELS-1:0] receive_clock_invert,
   input wire logic [CHANNELS-1:0] clock_output_enable,
   input wire logic [CHANNELS-1:0] lock_disable_control
);
   logic req_q;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // A held strobe is one access, so only its first sampled cycle is a take
   wire req = !cs_n && (!rd_n || !wr_n);
   wire take = ce && req && !req_q;
   wire take_rd = take && !rd_n;
   wire take_wr = take && rd_n && !wr_n;
   always_ff @(posedge clock) begin
      req_q <= reset ? 1'h0 : req;
   end
   property p_rdy_answer;
      take |=> rdy_n ##1 !rdy_n;
   endproperty
   a_rdy_answer: assert property (p_rdy_answer) else $error("ready late or early");
   property p_rdy_release;
      !rdy_n && !req |=> rdy_n;
   endproperty
   a_rdy_release: assert property (p_rdy_release) else $error("ready kept after release");
   property p_oe_read;
      take_rd |=> data_oe ##1 data_oe && !rdy_n;
   endproperty
   a_oe_read: assert property (p_oe_read) else $error("read bus not driven");
   property p_unmapped;
      take_rd && addr[7:4] > 4'h5 |=> data_out == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_alarm_rsv;
      take_rd && addr[3:0] == 4'h3 |=> !data_out[7];
   endproperty
   a_alarm_rsv: assert property (p_alarm_rsv) else $error("alarm reserved bit set");
   property p_tx_read;
      take_rd && addr == 8'h04 |=> data_out[0] == transmit_level_select[0] && data_out[7:6] == 2'h0;
   endproperty
   a_tx_read: assert property (p_tx_read) else $error("tx control read wrong");
   property p_rx_write;
      take_wr && addr == 8'h05 |=>
         equalizer_enable[0] == $past(data_in[0]) && receive_clock_invert[0] == $past(data_in[3]);
   endproperty
   a_rx_write: assert property (p_rx_write) else $error("rx control write lost");
   property p_blk_write;
      take_wr && addr == 8'h56 |=> clock_output_enable[5] == $past(data_in[6]);
   endproperty
   a_blk_write: assert property (p_blk_write) else $error("block control ch5 write lost");
   property p_ja_write;
      take_wr && addr == 8'h07 |=> lock_disable_control[0] == $past(data_in[4]);
   endproperty
   a_ja_write: assert property (p_ja_write) else $error("ja control write lost");
   property p_ctl_stable;
      !take_wr |=> $stable(transmit_level_select) && $stable(clock_output_enable);
   endproperty
   a_ctl_stable: assert property (p_ctl_stable) else $error("control changed without write");
   property p_irq_gate;
      !channel_irq_gate[1] [*4] |-> !channel_irq[1];
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("request not gated");
endmodule

bind lcr_top lcr_top_props #(.CHANNELS(CHANNELS)) lcr_top_props_u (.clock, .reset, .ce, .cs_n,
   .rd_n, .wr_n, .addr, .data_in, .data_out, .data_oe, .rdy_n, .channel_irq_gate, .channel_irq,
   .transmit_level_select, .equalizer_enable, .receive_clock_invert, .clock_output_enable,
   .lock_disable_control);

// ==== verification/tb_lui_channel_control_regs.sv ====
// Self-checking bench for the channel register bank
`timescale 1ns/1ns
`include "lcr_regs.svh"
module tb_lui_channel_control_regs;
   // Host port, events and control outputs
   logic clock, reset, ce, cs_n, rd_n, wr_n, data_oe, rdy_n;
   logic [7:0] addr, data_in, data_out, rd_v;
   logic [5:0] pattern_lock_state, digital_signal_loss, analog_signal_loss, fifo_limit_alarm;
   logic [5:0] receive_lock_loss, receive_signal_loss, driver_monitor_alarm, pattern_error;
   logic [5:0] channel_irq_gate, channel_irq, transmit_monitor_enable, pattern_insert;
   logic [5:0] transmit_all_ones, transmit_clock_invert, transmit_level_select;
   logic [5:0] digital_loss_disable, analog_loss_disable, receive_clock_invert;
   logic [5:0] mute_on_signal_loss, receive_monitor_mode, equalizer_enable, clock_output_enable;
   logic [5:0] pattern_generator_enable, remote_loopback, local_loopback, e3_rate_select;
   logic [5:0] sonet_vs_ds3_select, single_dual_rail, lock_disable_control, fifo_pointer_reset;
   logic [5:0] attenuator_mode_hi, attenuator_path_select, attenuator_mode_lo;
   logic [6:0] alm [6];
   logic [7:0] ctl [4];
   int num_errors, cmp_count, i, j;
   localparam logic [7:0] MSK [4] = '{`LCR_MASK_TX, `LCR_MASK_RX, `LCR_MASK_BLK, `LCR_MASK_JA};
   localparam logic [3:0] OFFS [8] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'ha, 4'hb, 4'hc};

   lcr_top #(.CHANNELS(6)) dut_u (.clock, .reset, .ce, .cs_n, .rd_n, .wr_n, .addr, .data_in,
      .data_out, .data_oe, .rdy_n, .pattern_lock_state, .digital_signal_loss, .analog_signal_loss,
      .fifo_limit_alarm, .receive_lock_loss, .receive_signal_loss, .driver_monitor_alarm,
      .pattern_error, .channel_irq_gate, .channel_irq, .transmit_monitor_enable, .pattern_insert,
      .transmit_all_ones, .transmit_clock_invert, .transmit_level_select, .digital_loss_disable,
      .analog_loss_disable, .receive_clock_invert, .mute_on_signal_loss, .receive_monitor_mode,
      .equalizer_enable, .clock_output_enable, .pattern_generator_enable, .remote_loopback,
      .local_loopback, .e3_rate_select, .sonet_vs_ds3_select, .single_dual_rail,
      .lock_disable_control, .fifo_pointer_reset, .attenuator_mode_hi, .attenuator_path_select,
      .attenuator_mode_lo);

   // Alarm levels per channel, packed in alarm status bit order
   always_comb begin
      for (int c = 0; c < 6; c++) begin
         {pattern_lock_state[c], digital_signal_loss[c], analog_signal_loss[c],
            fifo_limit_alarm[c], receive_lock_loss[c], receive_signal_loss[c],
            driver_monitor_alarm[c]} = alm[c];
      end
   end
   // Channel 0 control outputs rebuilt in register bit order
   assign ctl[0] = {2'h0, transmit_monitor_enable[0], pattern_insert[0], 1'h0,
      transmit_all_ones[0], transmit_clock_invert[0], transmit_level_select[0]};
   assign ctl[1] = {2'h0, digital_loss_disable[0], analog_loss_disable[0], receive_clock_invert[0],
      mute_on_signal_loss[0], receive_monitor_mode[0], equalizer_enable[0]};
   assign ctl[2] = {1'h0, clock_output_enable[0], pattern_generator_enable[0], remote_loopback[0],
      local_loopback[0], e3_rate_select[0], sonet_vs_ds3_select[0], single_dual_rail[0]};
   assign ctl[3] = {3'h0, lock_disable_control[0], fifo_pointer_reset[0], attenuator_mode_hi[0],
      attenuator_path_select[0], attenuator_mode_lo[0]};

   // Clock at 250 MHz
   initial begin
      clock = 1'h0;
      forever #2 clock = ~clock;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One access; request held until ready is sampled low, then released for an idle gap
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      cs_n <= 1'h0;
      rd_n <= wr;
      wr_n <= !wr;
      addr <= a;
      data_in <= d;
      do begin
         @(posedge clock);
         n++;
      end while (rdy_n !== 1'h0 && n < 16);
      if (n >= 16) num_errors++;
      rd_v = data_out;
      cs_n <= 1'h1;
      rd_n <= 1'h1;
      wr_n <= 1'h1;
      repeat (2) @(posedge clock);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      acc(1'h0, a, 8'h00);
      chk(rd_v, exp);
   endtask

   // Pattern error pulse (k 4) or alarm level toggle (k 0 to 3) on channel c
   task automatic evt(input int c, input int k);
      if (k == 4) begin
         pattern_error[c] <= 1'h1;
         @(posedge clock);
         pattern_error[c] <= 1'h0;
      end else begin
         alm[c][k] <= !alm[c][k];
         @(posedge clock);
      end
      @(posedge clock);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Watchdog sized above the long counter fill
   initial begin
      repeat (80000) @(posedge clock);
      num_errors++;
      give_verdict();
   end

   initial begin
      num_errors = 0;
      cmp_count = 0;
      reset = 1'h1;
      ce = 1'h1;
      {cs_n, rd_n, wr_n} = 3'h7;
      addr = 8'h00;
      data_in = 8'h00;
      pattern_error = 6'h00;
      channel_irq_gate = 6'h3f;
      alm = '{default: 7'h00};
      repeat (10) @(posedge clock);
      reset <= 1'h0;
      @(posedge clock);
      for (i = 0; i < 6; i++) for (j = 0; j < 8; j++) rdc({i[3:0], OFFS[j]}, 8'h00);
      $display("test reset map done");
      for (i = 0; i < 4; i++) for (j = 0; j < 8; j++) begin
         acc(1'h1, {4'h0, 4'h4 + i[3:0]}, 8'h01 << j);
         rdc({4'h0, 4'h4 + i[3:0]}, (8'h01 << j) & MSK[i]);
         chk(ctl[i], (8'h01 << j) & MSK[i]);
      end
      acc(1'h1, 8'h03, 8'hff);
      rdc(8'h03, 8'h00);
      acc(1'h1, 8'h64, 8'hff);
      rdc(8'h64, 8'h00);
      rdc(8'h04, 8'h00);
      $display("test field layout done");
      // Each channel's block control drives its own output bit
      for (i = 0; i < 6; i++) begin
         acc(1'h1, {i[3:0], 4'h6}, 8'h40);
         chk(clock_output_enable, 16'h003f >> (5 - i));
      end
      for (j = 0; j < 7; j++) begin
         alm[3] <= 7'h01 << j;
         repeat (2) @(posedge clock);
         rdc(8'h33, 8'h01 << j);
      end
      alm[3] <= 7'h00;
      $display("test channels and alarms done");
      acc(1'h1, 8'h17, 8'h01);
      for (j = 0; j < 5; j++) begin
         acc(1'h1, 8'h11, 8'h00);
         evt(1, j);
         rdc(8'h12, 8'h00);
         acc(1'h1, 8'h11, 8'h01 << j);
         evt(1, j);
         repeat (3) @(posedge clock);
         if (j == 0) begin
            channel_irq_gate[1] <= 1'h0;
            repeat (4) @(posedge clock);
            chk(channel_irq[1], 1'h0);
            channel_irq_gate[1] <= 1'h1;
            repeat (3) @(posedge clock);
         end
         chk(channel_irq[1], 1'h1);
         rdc(8'h12, 8'h01 << j);
         repeat (3) @(posedge clock);
         chk(channel_irq[1], 1'h0);
         rdc(8'h12, 8'h00);
      end
      // Attenuator off ignores the limit enable; entering the limit flags once it is on
      acc(1'h1, 8'h17, 8'h00);
      acc(1'h1, 8'h11, 8'h08);
      for (j = 0; j < 3; j++) begin
         if (j == 2) acc(1'h1, 8'h17, 8'h04);
         evt(1, 3);
         rdc(8'h12, (j == 2) ? 8'h08 : 8'h00);
      end
      $display("test interrupt sources done");
      for (j = 0; j < 3; j++) evt(0, 4);
      rdc(8'h0a, 8'h00);
      rdc(8'h0b, 8'h03);
      ce <= 1'h0;
      evt(0, 4);
      ce <= 1'h1;
      evt(0, 4);
      rdc(8'h0b, 8'h04);
      rdc(8'h0c, 8'h03);
      // Channel 4 saturation with only its enable set
      acc(1'h1, 8'h41, 8'h20);
      pattern_error[4] <= 1'h1;
      repeat (65540) @(posedge clock);
      pattern_error[4] <= 1'h0;
      repeat (3) @(posedge clock);
      chk(channel_irq[4], 1'h1);
      rdc(8'h4a, 8'hff);
      rdc(8'h4b, 8'hff);
      rdc(8'h42, 8'h20);
      $display("test error counter done");
      give_verdict();
   end
endmodule
